/* File: mfdc_top.v */
// Purpose: Modem format, whitening, deviation configuration block
// Assumes: APB slave on pclk; link pins synchronised two stages
// Notes:   One bit per bit strobe in NRZ, half a bit in Manchester; async formats ignore the strobe
//          Status word at index 0x20 is read-only
//          Clock enable low freezes every register
// Function
// - ADC clock is crystal over twice (code plus one), reset code 3.
// - ADC clock equals four times IF; software aims at 1.2288 MHz.
// - Whitening bit scrambles TX and RX with x^9+x^5+1 sequence.
// - Format 00 is NRZ and 01 is Manchester.
// - Formats 10 and 11 are async with data clock held low or high.
// - Deviation bit 7 enables Gaussian shaping, reset to one.
// - Deviation exponent bits 6:4 reset 6, mantissa bits 3:0 reset 8.
// - Low band deviation is fref times mantissa times 2^(exp-16).
// - High band deviation is fref times mantissa times 2^(exp-15).
// - Mantissa zero selects on-off keying for receive and transmit.
// - Reference frequency is crystal over the reference divisor.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "mfdc_defines.vh"
module mfdc_top #(
    parameter FREF_W = 24
) (
    // APB slave
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    input  wire [3:0]        pstrb,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // Clock enable
    input  wire              clk_en,
    // Clock sources and mode
    input  wire              xtal_tick,
    input  wire [FREF_W-1:0] fref_hz,
    input  wire              high_band,
    input  wire              tx_active,
    input  wire              rx_active,
    // Bit streams
    input  wire              bit_strobe,
    input  wire              tx_data_in,
    input  wire              rx_bit_in,
    output reg               tx_sym_out,
    output reg               rx_data_out,
    output reg               data_clock_out,
    // Modulator controls
    output reg               adc_clk_out,
    output reg               shaping_enable,
    output reg               ook_mode,
    output reg  [FREF_W+3:0] deviation_hz
);
    ////////////////////////////////////////////////////////////////////
    // Register copies, pin synchronisers and activity tracking
    reg  [7:0]        modem_q;
    reg  [7:0]        dev_q;
    reg  [1:0]        tx_sync_q;
    reg  [1:0]        rx_sync_q;
    reg               act_q;
    reg               half_q;
    reg               man_bit_q;
    reg  [FREF_W+3:0] dev_d;
    reg  [7:0]        status_d;
    wire              act_now;
    wire              adc_clk;
    wire              pn_bit;
    wire              wr_en;
    wire              rd_en;
    wire [9:0]        idx;
    wire [1:0]        fmt;
    wire [2:0]        tx_dev_exponent;
    wire [3:0]        tx_dev_mantissa;
    wire              whitening_enable;
    wire              tx_white;
    wire              rx_white;

    ////////////////////////////////////////////////////////////////////
    // Field decode
    // Fields sliced once here so every user sees the same bits
    // Bus index drops the two byte-offset bits of the address
    assign fmt              = modem_q[`MFDC_FMT_HI:`MFDC_FMT_LO];
    assign whitening_enable = modem_q[`MFDC_WHITEN_BIT];
    assign tx_dev_exponent  = dev_q[`MFDC_EXP_HI:`MFDC_EXP_LO];
    assign tx_dev_mantissa  = dev_q[`MFDC_MANT_HI:`MFDC_MANT_LO];
    assign idx              = paddr[11:2];
    assign act_now          = tx_active | rx_active;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    // Deviation scaled by a power of two, exponent offset per band
    // Product is four bits wider than the reference input
    // Shift is offset minus exponent, at least eight for legal codes
    function [FREF_W+3:0] dev_calc;
        input [FREF_W-1:0] fref;
        input [3:0]        mant;
        input [2:0]        expo;
        input [4:0]        ofs;
        reg   [FREF_W+3:0] prod;
        reg   [4:0]        sh;
        begin
            prod     = {4'h0, fref} * {{FREF_W{1'b0}}, mant};
            sh       = ofs - {2'h0, expo};
            dev_calc = prod >> sh;
        end
    endfunction

    // Whitening applied only while enabled
    // Same mask on both paths, so the far end undoes it alike
    function apply_white;
        input data;
        input en;
        input pn;
        begin
            apply_white = data ^ (en & pn);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // Host pins change on their own timing, hence two stages
    // Only the second stage feeds the data path
    // Both stages hold while the clock enable is low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sync_q <= 2'h0;
            rx_sync_q <= 2'h0;
        end else if (clk_en) begin
            tx_sync_q <= {tx_sync_q[0], tx_data_in};
            rx_sync_q <= {rx_sync_q[0], rx_bit_in};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB register file
    // Reserved modem bits masked off, so they always read zero
    // Only byte lane zero matters, registers are eight bits wide
    // Writes land at the access edge, never in the setup cycle
    // Status word is not writable, its address is ignored here
    // Held constant while clock enable is low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_q <= `MFDC_MODEM_RST;
            dev_q   <= `MFDC_DEV_RST;
        end else if (clk_en && wr_en && pstrb[0]) begin
            if (idx == {2'h0, `MFDC_IDX_MODEM}) begin
                modem_q <= pwdata[7:0] & `MFDC_MODEM_WMASK;
            end
            if (idx == {2'h0, `MFDC_IDX_DEV}) begin
                dev_q <= pwdata[7:0];
            end
        end
    end

    // Status word: activity, OOK, current sequence bit, format
    // Lets software see the sequence bit during bit error tests
    always @* begin
        status_d = {3'h0, act_q, ook_mode, pn_bit, fmt};
    end

    // Read data, one wait-free access phase, unmapped reads error
    // Data captured in the setup cycle, shown in the access cycle
    // Ready and error stand together for exactly one cycle
    // A write to the read-only status word is flagged as an error
    // Read data holds until the next setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (rd_en) begin
                if (idx == {2'h0, `MFDC_IDX_MODEM}) begin
                    prdata <= {24'h0, modem_q};
                end else if (idx == {2'h0, `MFDC_IDX_DEV}) begin
                    prdata <= {24'h0, dev_q};
                end else if (idx == {2'h0, `MFDC_IDX_STATUS}) begin
                    prdata <= {24'h0, status_d};
                end else begin
                    prdata  <= 32'h0;
                    pslverr <= 1'b1;
                end
            end else if (psel & ~penable) begin
                prdata  <= 32'h0;
                pslverr <= ~((idx == {2'h0, `MFDC_IDX_MODEM}) |
                             (idx == {2'h0, `MFDC_IDX_DEV}));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Whitening generator
    // Rise of tx or rx activity from idle reseeds, keeping both link ends aligned
    // Sequence steps once per strobe only while active
    mfdc_pn9 u_pn9 (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .restart (act_now & ~act_q),
        .advance (bit_strobe & act_q),
        .pn_bit  (pn_bit)
    );

    // ADC clock divider
    // Code zero is unsupported and simply parks the clock
    // Software picks the code for an ADC clock near four times IF
    mfdc_adc_div u_adc (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .xtal_tick (xtal_tick),
        .div_code  (modem_q[`MFDC_ADC_HI:`MFDC_ADC_LO]),
        .adc_clk_q (adc_clk)
    );

    // Whitened bits for both directions
    assign tx_white = apply_white(tx_sync_q[1], whitening_enable, pn_bit);
    assign rx_white = apply_white(rx_sync_q[1], whitening_enable, pn_bit);

    // Deviation from reference frequency, band selects offset
    // Upper band uses an offset one smaller, so twice the deviation
    // Mantissa zero gives zero here; the keying flag covers that case
    always @* begin
        if (high_band) begin
            dev_d = dev_calc(fref_hz, tx_dev_mantissa, tx_dev_exponent,
                             `MFDC_HIGH_BAND_OFS);
        end else begin
            dev_d = dev_calc(fref_hz, tx_dev_mantissa, tx_dev_exponent,
                             `MFDC_LOW_BAND_OFS);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data path and outputs
    // Every output registered; deviation trails its fields by a cycle
    // Sync formats: symbols move only on a strobe, data clock follows
    // Manchester: one strobe per half bit, first half carries the bit
    // Async formats: data passes every cycle, data clock parked
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q          <= 1'b0;
            half_q         <= 1'b0;
            man_bit_q      <= 1'b0;
            tx_sym_out     <= 1'b0;
            rx_data_out    <= 1'b0;
            data_clock_out <= 1'b0;
            adc_clk_out    <= 1'b0;
            shaping_enable <= 1'b1;
            ook_mode       <= 1'b0;
            deviation_hz   <= {(FREF_W+4){1'b0}};
        end else if (clk_en) begin
            act_q          <= act_now;
            adc_clk_out    <= adc_clk;
            shaping_enable <= dev_q[`MFDC_SHAPE_BIT];
            ook_mode       <= (tx_dev_mantissa == 4'h0);
            deviation_hz   <= dev_d;
            case (fmt)
                `MFDC_FMT_NRZ: begin
                    data_clock_out <= bit_strobe;
                    if (bit_strobe) begin
                        tx_sym_out  <= tx_white;
                        rx_data_out <= rx_white;
                    end
                end
                `MFDC_FMT_MANCH: begin
                    data_clock_out <= bit_strobe;
                    if (bit_strobe) begin
                        half_q <= ~half_q;
                        if (!half_q) begin
                            man_bit_q   <= tx_white;
                            tx_sym_out  <= tx_white;
                            rx_data_out <= rx_white;
                        end else begin
                            tx_sym_out <= ~man_bit_q;
                        end
                    end
                end
                `MFDC_FMT_ASYNC_LO: begin
                    data_clock_out <= 1'b0;
                    tx_sym_out     <= tx_white;
                    rx_data_out    <= rx_white;
                end
                default: begin
                    data_clock_out <= 1'b1;
                    tx_sym_out     <= tx_white;
                    rx_data_out    <= rx_white;
                end
            endcase
        end
    end
endmodule // mfdc_top
`default_nettype wire

/* File: mfdc_defines.vh */
// Purpose: Shared constants for the modem format and deviation block
// Assumes: APB byte addresses are four times the printed register index
// Notes:   Definitions only
`ifndef MFDC_DEFINES_VH
`define MFDC_DEFINES_VH
// Register indices
`define MFDC_IDX_MODEM      8'h0d
`define MFDC_IDX_DEV        8'h0e
`define MFDC_IDX_STATUS     8'h20
// Reset values
`define MFDC_MODEM_RST      8'h30
`define MFDC_DEV_RST        8'he8
// Modem register fields
`define MFDC_ADC_HI         6
`define MFDC_ADC_LO         4
`define MFDC_WHITEN_BIT     2
`define MFDC_FMT_HI         1
`define MFDC_FMT_LO         0
`define MFDC_MODEM_WMASK    8'h77
// Deviation register fields
`define MFDC_SHAPE_BIT      7
`define MFDC_EXP_HI         6
`define MFDC_EXP_LO         4
`define MFDC_MANT_HI        3
`define MFDC_MANT_LO        0
// Data formats
`define MFDC_FMT_NRZ        2'h0
`define MFDC_FMT_MANCH      2'h1
`define MFDC_FMT_ASYNC_LO   2'h2
`define MFDC_FMT_ASYNC_HI   2'h3
// Whitening sequence seed
`define MFDC_PN9_SEED       9'h1ff
// Deviation formula exponent offsets
`define MFDC_LOW_BAND_OFS   5'h10
`define MFDC_HIGH_BAND_OFS  5'h0f
`endif

/* File: mfdc_pn9.v */
// Purpose: Nine stage whitening sequence generator
// Assumes: Advance strobe once per bit
// Notes:   Polynomial x^9 + x^5 + 1, reseeded on restart
`timescale 1ns/1ps
`default_nettype none
`include "mfdc_defines.vh"
module mfdc_pn9 (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    input  wire       clk_en,
    // Control
    input  wire       restart,
    input  wire       advance,
    // Sequence bit
    output wire       pn_bit
);
    reg [8:0] lfsr_q;

    ////////////////////////////////////////////////////////////////////
    // Shift register, seeded at each activation
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_q <= `MFDC_PN9_SEED;
        end else if (clk_en) begin
            if (restart) begin
                lfsr_q <= `MFDC_PN9_SEED;
            end else if (advance) begin
                lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
            end
        end
    end

    assign pn_bit = lfsr_q[8];
endmodule // mfdc_pn9
`default_nettype wire

/* File: mfdc_adc_div.v */
// Purpose: ADC clock divider from the crystal clock
// Assumes: Crystal clock enable ticks in pclk domain
// Notes:   Output toggles every (code+1) ticks, period 2*(code+1)
`timescale 1ns/1ps
`default_nettype none
`include "mfdc_defines.vh"
module mfdc_adc_div (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    input  wire       clk_en,
    // Crystal tick and divisor code
    input  wire       xtal_tick,
    input  wire [2:0] div_code,
    // Divided clock
    output reg        adc_clk_q
);
    reg [2:0] cnt_q;

    ////////////////////////////////////////////////////////////////////
    // Half period counter, code 0 stops the clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= 3'h0;
            adc_clk_q <= 1'b0;
        end else if (clk_en && xtal_tick && div_code != 3'h0) begin
            if (cnt_q >= div_code) begin
                cnt_q     <= 3'h0;
                adc_clk_q <= ~adc_clk_q;
            end else begin
                cnt_q <= cnt_q + 3'h1;
            end
        end
    end
endmodule // mfdc_adc_div
`default_nettype wire

/* File: mfdc_host_model.sv */
// Purpose: Host side serial bit source and capture for the modem block
// Assumes: One bit every eight pclk cycles while run is high
// Notes:   Radio pin is looped back from the transmit symbol
`timescale 1ns/1ps
`default_nettype none
module mfdc_host_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control from bench
    input  wire logic        run,
    input  wire logic        send_bit,
    // Design side
    input  wire logic        tx_sym_out,
    output var  logic        bit_strobe,
    output var  logic        tx_data_in,
    output var  logic        rx_bit_in,
    // Captured transmit symbols
    output var  logic [15:0] cap_q,
    output var  logic [4:0]  nbits_q
);
    logic [2:0] cnt_q;
    ////////////////////////////////////////////////////////////////////////
    // Bit timing, constant data stream, capture of sixteen symbols
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {cnt_q, bit_strobe, cap_q, nbits_q} <= '0;
        end else if (!run) begin
            cnt_q      <= 3'h5; // First strobe lands before first capture
            bit_strobe <= 1'b0;
            nbits_q    <= 5'h00;
        end else begin
            cnt_q      <= cnt_q + 3'h1;
            bit_strobe <= (cnt_q == 3'h0);
            if (cnt_q == 3'h4 && nbits_q < 5'h10) begin
                cap_q   <= {cap_q[14:0], tx_sym_out};
                nbits_q <= nbits_q + 5'h01;
            end
        end
    end
    // All-zero stream allowed for error counting; air loopback
    always @(posedge pclk) begin
        tx_data_in <= send_bit;
        rx_bit_in  <= tx_sym_out;
    end
endmodule // mfdc_host_model
`default_nettype wire

/* File: mfdc_assertions.sv */
// Purpose: Port level checks of the modem format and deviation block
// Assumes: Shadow registers follow APB writes at the access edge
// Notes:   Bound into mfdc_top
`timescale 1ns/1ps
`default_nettype none
module mfdc_assertions #(parameter FREF_W = 24) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    input  wire logic              clk_en,
    input  wire logic [FREF_W-1:0] fref_hz,
    input  wire logic              high_band,
    input  wire logic              bit_strobe,
    input  wire logic              data_clock_out,
    input  wire logic              shaping_enable,
    input  wire logic              ook_mode,
    input  wire logic [FREF_W+3:0] deviation_hz
);
    logic [7:0]        modem_q;
    logic [7:0]        dev_q;
    logic [FREF_W+3:0] dev_x;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // Shadow copies of both registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_q <= 8'h30;
            dev_q   <= 8'he8;
        end else if (psel && penable && pwrite && pstrb[0] && clk_en) begin
            if (paddr == 12'h034) modem_q <= pwdata[7:0] & 8'h77;
            if (paddr == 12'h038) dev_q <= pwdata[7:0];
        end
    end
    // Expected deviation from the shadow fields
    always @* begin
        dev_x = ({4'h0, fref_hz} * dev_q[3:0])
              >> ((high_band ? 5'h0f : 5'h10) - {2'h0, dev_q[6:4]});
    end
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    sequence s_cfg_quiet;
        ($stable(dev_q) && $stable(fref_hz) && $stable(high_band)
            && clk_en) [*3];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (s_setup ##1 clk_en |-> pready)
        else $error("pready missing in access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    a_err_unmapped: assert property (pready |-> pslverr == !(paddr ==
        12'h034 || paddr == 12'h038 || (paddr == 12'h080 && !pwrite)))
        else $error("pslverr wrong for address");
    a_read_modem_reg: assert property (pready && !pwrite &&
        paddr == 12'h034 |-> prdata == {24'h0, modem_q})
        else $error("modem register read wrong");
    a_data_clock_out_async_low: assert property ((modem_q[1:0] == 2'h2) [*2]
        |-> !data_clock_out) else $error("data clock not low");
    a_data_clock_out_async_high: assert property ((modem_q[1:0] == 2'h3) [*2]
        |-> data_clock_out) else $error("data clock not high");
    a_data_clock_out_sync_fmt: assert property ((!modem_q[1]) [*2]
        |-> data_clock_out == $past(bit_strobe))
        else $error("data clock not following bit timing");
    a_ook_from_mant: assert property (s_cfg_quiet
        |-> ook_mode == (dev_q[3:0] == 4'h0)) else $error("ook mode wrong");
    a_shaping_bit: assert property (s_cfg_quiet
        |-> shaping_enable == dev_q[7]) else $error("shaping wrong");
    a_deviation_value: assert property (s_cfg_quiet
        |-> deviation_hz == dev_x) else $error("deviation value wrong");
endmodule // mfdc_assertions
bind mfdc_top mfdc_assertions #(.FREF_W(FREF_W)) mfdc_assertions_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .clk_en, .fref_hz, .high_band, .bit_strobe,
    .data_clock_out, .shaping_enable, .ook_mode, .deviation_hz);
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench for the modem format and deviation block
// Assumes: Crystal tick every cycle, zero wait state APB slave
// Notes:   Register rows first, then divisor, deviation, whitening
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;
    } mfdc_row_t;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic        pready, pslverr, e, high_band = 0, tx_active = 0;
    logic        rx_active = 0, send_bit = 0, bit_strobe, tx_data_in;
    logic        clk_en = 1;
    logic        rx_bit_in, tx_sym_out, rx_data_out, data_clock_out;
    logic        adc_clk_out, shaping_enable, ook_mode, last_adc;
    logic [23:0] fref_hz = 24'h123456;
    logic [27:0] deviation_hz;
    logic [15:0] cap_q, pn;
    logic [8:0]  st;
    logic [4:0]  nbits_q;
    logic [7:0]  dv;
    int          fails = 0, n_compared = 0, cyc = 0, p;
    mfdc_row_t   rows [10] = '{
        '{0, 12'h034, 0, 32'h30, 0}, '{0, 12'h038, 0, 32'he8, 0},
        '{1, 12'h034, 32'hff, 0, 0}, '{0, 12'h034, 0, 32'h77, 0},
        '{1, 12'h038, 32'h5a, 0, 0}, '{0, 12'h038, 0, 32'h5a, 0},
        '{0, 12'h100, 0, 0, 1},      '{1, 12'h03c, 32'h1, 0, 1},
        '{1, 12'h080, 32'h1, 0, 1},  '{0, 12'h080, 0, 32'h07, 0}};
    always #5 pclk = ~pclk;
    always @(posedge pclk) last_adc <= adc_clk_out;
    mfdc_top #(.FREF_W(24)) mfdc_top_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'h1), .prdata, .pready, .pslverr,
        .clk_en, .xtal_tick(1'b1), .fref_hz, .high_band, .tx_active,
        .rx_active, .bit_strobe, .tx_data_in, .rx_bit_in, .tx_sym_out,
        .rx_data_out, .data_clock_out, .adc_clk_out, .shaping_enable,
        .ook_mode, .deviation_hz);
    mfdc_host_model mfdc_host_model_inst (.pclk, .presetn,
        .run(tx_active | rx_active), .send_bit, .tx_sym_out, .bit_strobe,
        .tx_data_in, .rx_bit_in, .cap_q, .nbits_q);
    ////////////////////////////////////////////////////////////////////////
    // Closing report and hang guard
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done;
        end
    end
    task check(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // One APB transfer, waits for pready at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Cycles between two rises of the ADC clock
    task adc_period;
        repeat (2) begin
            p = 0;
            do begin @(posedge pclk); p++; end
            while (!(adc_clk_out === 1'b1 && last_adc === 1'b0) && p < 100);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        check(shaping_enable, 1'b1);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            check(e, rows[i].e);
            if (!rows[i].w) check(r, rows[i].x);
        end
        for (int c = 1; c < 8; c++) begin
            apb(1, 12'h034, c << 4);
            adc_period;
            check(p, 2 * (c + 1));
        end
        for (int b = 0; b < 2; b++) begin
            for (int j = 0; j < 3; j++) begin
                dv = (j == 0) ? 8'he8 : (j == 1) ? 8'h7f : 8'h10;
                high_band <= b[0];
                apb(1, 12'h038, dv);
                repeat (4) @(posedge pclk);
                check(deviation_hz, ({4'h0, fref_hz} * dv[3:0]) >>
                    ((b ? 15 : 16) - dv[6:4]));
                check(ook_mode, dv[3:0] == 4'h0);
                check(shaping_enable, dv[7]);
            end
        end
        // Clock enable low freezes outputs, release lets them follow
        apb(1, 12'h038, 8'he8);
        repeat (2) @(posedge pclk);
        clk_en  <= 1'b0;
        fref_hz <= 24'h654321;
        repeat (4) @(posedge pclk);
        check(deviation_hz, ({4'h0, 24'h123456} * 4'h8) >> 9);
        clk_en <= 1'b1;
        repeat (4) @(posedge pclk);
        check(deviation_hz, ({4'h0, 24'h654321} * 4'h8) >> 9);
        for (int f = 2; f < 4; f++) begin
            apb(1, 12'h034, 8'h30 | f);
            rx_active <= 1'b1;
            repeat (30) @(posedge pclk);
            check(data_clock_out, f[0]);
            rx_active <= 1'b0;
        end
        for (int k = 0; k < 4; k++) begin
            apb(1, 12'h034, (k == 0) ? 8'h30 : (k == 3) ? 8'h31 : 8'h34);
            send_bit <= (k == 0 || k == 3);
            st = 9'h1ff;
            for (int i = 0; i < 16; i++) begin
                pn = {pn[14:0], (k == 3) ? !i[0] : (st[8] | (k == 0))};
                st = {st[7:0], st[8] ^ st[4]};
            end
            repeat (4) @(posedge pclk);
            tx_active <= 1'b1;
            p = 0;
            do begin @(posedge pclk); p++; end
            while (nbits_q !== 5'h10 && p < 400);
            check(cap_q, pn);
            if (k == 0) check(rx_data_out, 1'b1);
            tx_active <= 1'b0;
        end
        test_done;
    end
endmodule // tb_top
`default_nettype wire
